// File: pkg/fsps_pkg.sv
// ============================================================
// Flash self-programming sequencer package
// ============================================================
// Shared constants for the core-side and device-side ends.
// Assumes a 50 MHz single clock and synchronous active-high reset.
package fsps_pkg;
    // ========================================================
    // Clock and timing
    // ========================================================
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned PROG_MIN_US     = 3700;           // Least programming time, us
    localparam int unsigned PROG_MAX_US     = 4500;           // Longest programming time, us
    // Least time in cycles; cycles per us is a truncated whole number
    localparam int unsigned PROG_MIN_CYC    = (PROG_MIN_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CMD_WINDOW_CYC  = 4;              // Store must follow within this
    // ========================================================
    // Address layout
    // ========================================================
    localparam int unsigned PTR_W     = 16;
    localparam int unsigned WORD_W    = 6;                    // Word field above byte bit
    localparam int unsigned PAGE_LSB  = WORD_W + 1;
    localparam int unsigned PAGE_W    = PTR_W - PAGE_LSB;
    localparam int unsigned BUF_DEPTH = 1 << WORD_W;
    localparam int unsigned HALT_FIRST_PAGE = 112;            // Pages at and above halt the core
    localparam logic [15:0] APP_RESET_ADDR  = 16'h0000;
    localparam logic [15:0] BOOT_RESET_ADDR = 16'h1c00;
    // ========================================================
    // Control register fields
    // ========================================================
    localparam int unsigned CTL_ENABLE_BIT   = 0;
    localparam int unsigned CTL_ERASE_BIT    = 1;
    localparam int unsigned CTL_WRITE_BIT    = 2;
    localparam int unsigned CTL_LOCKSET_BIT  = 3;
    localparam int unsigned CTL_REENABLE_BIT = 4;
    localparam int unsigned CTL_BUSY_BIT     = 6;
    localparam int unsigned CTL_IRQEN_BIT    = 7;
    localparam logic [6:0]  CMD_MASK         = 7'h7f;         // Bit 7 is "X" in patterns
    localparam logic [6:0]  CMD_ERASE        = 7'h03;
    localparam logic [6:0]  CMD_LOAD         = 7'h01;
    localparam logic [6:0]  CMD_WRITE        = 7'h05;
    localparam logic [6:0]  CMD_LOCK         = 7'h09;
    localparam logic [6:0]  CMD_REENABLE     = 7'h11;
    localparam logic [7:0]  CTL_RESET        = 8'h00;

    typedef enum logic [1:0] {
        FSPS_IDLE  = 2'b00,
        FSPS_ARMED = 2'b01,
        FSPS_BUSY  = 2'b11
    } fsps_state_e;
endpackage

// File: pkg/fsps_if.sv
// ============================================================
// Link between core side and flash sequencer device side
// ============================================================
// Single clock; core drives pointer, data pair and strobes.
`timescale 1ns/100ps
interface fsps_if;
    logic        ctl_wr;      // Core writes control register
    logic [7:0]  ctl_wdata;   // Control write value
    logic [7:0]  ctl_rdata;   // Control register read value
    logic        store;       // Store instruction executed
    logic [15:0] ptr;         // Address pointer pair
    logic [15:0] wdata;       // Write data pair
    logic        ee_write;    // Data EEPROM write seen
    logic        halt;        // Core must stall
    logic        irq;         // Level completion interrupt
    logic [15:0] reset_vec;   // Reset fetch address
    modport device (input ctl_wr, ctl_wdata, store, ptr, wdata, ee_write,
                    output ctl_rdata, halt, irq, reset_vec);
    modport core (output ctl_wr, ctl_wdata, store, ptr, wdata, ee_write,
                  input ctl_rdata, halt, irq, reset_vec);
endinterface

// File: design/fsps_device.sv
// ============================================================
// Flash self-programming sequencer, device end
// ============================================================
// Holds the control register, command window, page buffer and
// programming timer. Assumes the core honours halt and the flash
// array is modelled by the user ports.
`timescale 1ns/100ps
module fsps_device
    import fsps_pkg::*;
#(
    parameter int unsigned PROG_CYC = PROG_MIN_CYC          // Programming duration
) (
    input  wire logic             mclk,            // 50 MHz clock
    input  wire logic             rst,             // Sync reset, high
    fsps_if.device                lnk,             // Core link
    input  wire logic             boot_vector_select_fuse, // 0 = boot start
    output logic                  flash_erase,     // Pulse: erase page
    output logic                  flash_write,     // Pulse: write page
    output logic                  flash_lock,      // Pulse: set lock bits
    output logic [PAGE_W-1:0]     flash_page,      // Latched page
    output logic [15:0]           flash_lock_data, // Lock data from pair
    output logic [WORD_W-1:0]     buf_rd_idx,      // Readback index echo of pointer word field
    output logic [15:0]           buf_rd_word      // Buffer word at index
);
    import fsps_pkg::*;

    fsps_state_e                 state_ff;
    logic [6:0]                  cmd_ff;
    logic [2:0]                  win_ff;
    logic                        busy_ff;
    logic                        irqen_ff;
    logic                        halt_ff;
    logic [31:0]                 tmr_ff;
    logic [15:0]                 buf_ff [BUF_DEPTH];
    logic [BUF_DEPTH-1:0]        bufv_ff;
    logic [PAGE_W-1:0]           page_ff;
    logic [15:0]                 vec_ff;
    logic                        fuse_s1_ff, fuse_s2_ff;
    logic [15:0]                 lockd_ff;
    logic                        er_ff, wr_ff, lk_ff;
    logic                        go_erase, go_write, go_load, go_lock, reen, done;

    function automatic logic is_halting(input logic [PAGE_W-1:0] pg);
        is_halting = (32'(pg) >= HALT_FIRST_PAGE);
    endfunction

    // ========================================================
    // Command decode
    // ========================================================
    // Store only acts while armed inside the window
    assign go_erase = (state_ff == FSPS_ARMED) && lnk.store && (cmd_ff == CMD_ERASE);
    assign go_load  = (state_ff == FSPS_ARMED) && lnk.store && (cmd_ff == CMD_LOAD);
    assign go_write = (state_ff == FSPS_ARMED) && lnk.store && (cmd_ff == CMD_WRITE);
    assign go_lock  = (state_ff == FSPS_ARMED) && lnk.store && (cmd_ff == CMD_LOCK);
    // Reenable is a command write on its own, no store needed
    assign reen     = lnk.ctl_wr && ((lnk.ctl_wdata[6:0] & CMD_MASK) == CMD_REENABLE)
                      && (state_ff != FSPS_BUSY);
    assign done     = (state_ff == FSPS_BUSY) && (tmr_ff == 32'd1);

    // ========================================================
    // Sequencer state and command window
    // ========================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= FSPS_IDLE;
            cmd_ff   <= 7'h00;
            win_ff   <= 3'd0;
            tmr_ff   <= 32'd0;
        end else begin
            case (state_ff)
                FSPS_IDLE: begin
                    if (lnk.ctl_wr && lnk.ctl_wdata[CTL_ENABLE_BIT] && !reen) begin
                        state_ff <= FSPS_ARMED;
                        cmd_ff   <= lnk.ctl_wdata[6:0] & CMD_MASK;
                        win_ff   <= 3'(CMD_WINDOW_CYC);
                    end
                end
                FSPS_ARMED: begin
                    if (go_erase || go_write || go_lock) begin
                        state_ff <= FSPS_BUSY;
                        tmr_ff   <= PROG_CYC;
                    end else if (lnk.store || win_ff == 3'd1) begin
                        state_ff <= FSPS_IDLE;
                        cmd_ff   <= 7'h00;
                    end else begin
                        win_ff <= win_ff - 3'd1;
                    end
                end
                FSPS_BUSY: begin
                    if (done) begin
                        state_ff <= FSPS_IDLE;
                        cmd_ff   <= 7'h00;
                    end else begin
                        tmr_ff <= tmr_ff - 32'd1;
                    end
                end
                default: state_ff <= FSPS_IDLE;
            endcase
        end
    end

    // ========================================================
    // Address latch and flash pulses
    // ========================================================
    // Latching lets software reuse the pointer at once
    always_ff @(posedge mclk) begin
        if (rst) begin
            page_ff  <= '0;
            lockd_ff <= 16'h0000;
            er_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            lk_ff    <= 1'b0;
        end else begin
            er_ff <= go_erase;
            wr_ff <= done && (cmd_ff == CMD_WRITE);
            lk_ff <= go_lock;
            if (go_erase || go_write)
                page_ff <= lnk.ptr[PTR_W-1:PAGE_LSB];
            if (go_lock)
                lockd_ff <= lnk.wdata;
        end
    end

    // ========================================================
    // Halt and busy flag
    // ========================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            halt_ff  <= 1'b0;
            busy_ff  <= 1'b0;
            irqen_ff <= 1'b0;
        end else begin
            if (lnk.ctl_wr)
                irqen_ff <= lnk.ctl_wdata[CTL_IRQEN_BIT];
            if (go_erase || go_write)
                halt_ff <= is_halting(lnk.ptr[PTR_W-1:PAGE_LSB]);
            else if (done)
                halt_ff <= 1'b0;
            // Set wins over clear; reen is blocked while busy anyway
            if (go_erase || go_write)
                busy_ff <= 1'b1;
            else if (reen)
                busy_ff <= 1'b0;
        end
    end

    // ========================================================
    // Temporary page buffer
    // ========================================================
    // Valid bits allow random order; a reload of a word is ignored
    always_ff @(posedge mclk) begin
        if (rst) begin
            bufv_ff <= '0;
            for (int i = 0; i < BUF_DEPTH; i++)
                buf_ff[i] <= 16'hffff;
        end else if ((done && cmd_ff == CMD_WRITE) || reen || lnk.ee_write) begin
            bufv_ff <= '0;
            for (int i = 0; i < BUF_DEPTH; i++)
                buf_ff[i] <= 16'hffff;
        end else if (go_load && !bufv_ff[lnk.ptr[WORD_W:1]]) begin
            buf_ff[lnk.ptr[WORD_W:1]]  <= lnk.wdata;
            bufv_ff[lnk.ptr[WORD_W:1]] <= 1'b1;
        end
    end

    // ========================================================
    // Reset vector, fuse read only
    // ========================================================
    // Fuse level comes from outside the clock domain: two stages first.
    // No reset here, so the value has settled before reset is released.
    always_ff @(posedge mclk) begin
        fuse_s1_ff <= boot_vector_select_fuse;
        fuse_s2_ff <= fuse_s1_ff;
    end

    // Fuse is an input only; nothing here can write it
    always_ff @(posedge mclk) begin
        if (rst)
            vec_ff <= 16'h0000;
        else
            vec_ff <= fuse_s2_ff ? APP_RESET_ADDR : BOOT_RESET_ADDR;
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign lnk.ctl_rdata = {irqen_ff, busy_ff, 1'b0, 4'b0000,
                            state_ff != FSPS_IDLE} | {1'b0, 7'(cmd_ff & {7{state_ff != FSPS_IDLE}})};
    assign lnk.halt      = halt_ff;
    assign lnk.irq       = irqen_ff && (state_ff == FSPS_IDLE);
    assign lnk.reset_vec = vec_ff;
    assign flash_erase     = er_ff;
    assign flash_write     = wr_ff;
    assign flash_lock      = lk_ff;
    assign flash_page      = page_ff;
    assign flash_lock_data = lockd_ff;
    assign buf_rd_idx      = lnk.ptr[WORD_W:1];
    assign buf_rd_word     = buf_ff[lnk.ptr[WORD_W:1]];
endmodule

// File: design/fsps_core.sv
// ============================================================
// Flash self-programming sequencer, core end
// ============================================================
// Turns software register requests into link strobes. Assumes
// software keeps vectors away from the blocked section.
`timescale 1ns/100ps
module fsps_core
    import fsps_pkg::*;
(
    input  wire logic        mclk,      // 50 MHz clock
    input  wire logic        rst,       // Sync reset, high
    fsps_if.core             lnk,       // Device link
    input  wire logic [1:0]  addr,      // 0 ctl, 1 ptr, 2 data, 3 store; reads of 2 or 3 give reset vector
    input  wire logic [15:0] wr_data,   // Write data
    input  wire logic        wr_en,     // Write strobe
    input  wire logic        rd_en,     // Read strobe
    output logic [15:0]      rd_data,   // Read data, next cycle
    input  wire logic        ee_wr_req, // EEPROM write happening
    output logic             stalled,   // Core halted by device
    output logic             irq_req    // Interrupt to core
);
    import fsps_pkg::*;

    logic [15:0] ptr_ff, dat_ff, rd_ff;
    logic [7:0]  ctl_ff;
    logic        cwr_ff, st_ff, ee_ff;

    // ========================================================
    // Control and store writes become one-cycle link strobes
    // ========================================================
    // Stores are dropped while halted, as a stalled core runs nothing
    always_ff @(posedge mclk) begin
        if (rst) begin
            ptr_ff <= 16'h0000;
            dat_ff <= 16'h0000;
            ctl_ff <= CTL_RESET;
            cwr_ff <= 1'b0;
            st_ff  <= 1'b0;
            ee_ff  <= 1'b0;
        end else begin
            cwr_ff <= wr_en && addr == 2'd0 && !lnk.halt;
            st_ff  <= wr_en && addr == 2'd3 && !lnk.halt;
            ee_ff  <= ee_wr_req;
            if (wr_en && addr == 2'd0)
                ctl_ff <= wr_data[7:0];
            if (wr_en && addr == 2'd1)
                ptr_ff <= wr_data;
            if (wr_en && addr == 2'd2)
                dat_ff <= wr_data;
        end
    end

    // ========================================================
    // Read port
    // ========================================================
    always_ff @(posedge mclk) begin
        if (rst)
            rd_ff <= 16'h0000;
        else if (rd_en)
            rd_ff <= (addr == 2'd0) ? {8'h00, lnk.ctl_rdata} :
                     (addr == 2'd1) ? ptr_ff : lnk.reset_vec;
    end

    assign rd_data       = rd_ff;
    assign lnk.ctl_wr    = cwr_ff;
    assign lnk.ctl_wdata = ctl_ff;
    assign lnk.store     = st_ff;
    assign lnk.ptr       = ptr_ff;
    assign lnk.wdata     = dat_ff;
    assign lnk.ee_write  = ee_ff;
    assign stalled       = lnk.halt;
    assign irq_req       = lnk.irq;
endmodule

// File: bench/fsps_link_monitor.sv
// ============================================================
// Concurrent checks on the link between core end and device end.
// Assumes one clock, synchronous high reset and the package field map.
`timescale 1ns/100ps
module fsps_link_monitor
    import fsps_pkg::*;
#(
    parameter int unsigned PROG_CYC = 20            // Programming duration
) (
    input  wire logic        mclk,                  // Clock
    input  wire logic        rst,                   // Sync reset, high
    input  wire logic        ctl_wr,                // Control write strobe
    input  wire logic [7:0]  ctl_wdata,             // Control write value
    input  wire logic [7:0]  ctl_rdata,             // Control readback
    input  wire logic        store,                 // Store strobe
    input  wire logic [15:0] ptr,                   // Address pointer
    input  wire logic        halt,                  // Core stall
    input  wire logic        irq,                   // Completion interrupt
    input  wire logic [15:0] reset_vec              // Reset fetch address
);
    // ========================================================
    // Helper logic
    // ========================================================
    // Halt length in cycles; far beyond what a repetition may unroll
    logic [31:0] halt_cnt_ff;
    always_ff @(posedge mclk) begin
        if (rst || !halt)
            halt_cnt_ff <= '0;
        else
            halt_cnt_ff <= halt_cnt_ff + 32'd1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ========================================================
    // Assertions
    // ========================================================
    irq_when_idle_a: assert property (irq |-> !ctl_rdata[CTL_ENABLE_BIT])
        else $error("interrupt raised while enable bit set");
    window_expiry_a: assert property ($rose(ctl_rdata[CTL_ENABLE_BIT]) ##1 (!store)[*6]
        |-> !ctl_rdata[CTL_ENABLE_BIT]) else $error("command bits kept without store");
    busy_on_start_a: assert property (store && ctl_rdata[CTL_ENABLE_BIT] && !halt
        && (ctl_rdata[CTL_ERASE_BIT] || ctl_rdata[CTL_WRITE_BIT]) && !ctl_rdata[CTL_BUSY_BIT]
        |=> ctl_rdata[CTL_BUSY_BIT]) else $error("busy flag not set by erase or write");
    busy_release_a: assert property ($fell(ctl_rdata[CTL_BUSY_BIT]) |-> $past(ctl_wr)
        && (($past(ctl_wdata) & 8'h7f) == {1'b0, CMD_REENABLE}))
        else $error("busy flag cleared without reenable write");
    halt_release_a: assert property ($fell(halt) |-> !ctl_rdata[CTL_ENABLE_BIT]
        && ctl_rdata[CTL_BUSY_BIT]) else $error("halt released out of step with enable");
    halt_section_a: assert property ($rose(ctl_rdata[CTL_BUSY_BIT])
        |-> halt == (int'($past(ptr) >> PAGE_LSB) >= HALT_FIRST_PAGE))
        else $error("halt does not match target section");
    halt_has_busy_a: assert property (halt |-> ctl_rdata[CTL_BUSY_BIT])
        else $error("core halted without busy flag");
    op_length_a: assert property ($fell(halt) |-> (halt_cnt_ff >= PROG_CYC - 1)
        && (halt_cnt_ff <= PROG_CYC + 1)) else $error("operation length off");
    op_bound_a: assert property (halt |-> halt_cnt_ff <= PROG_CYC + 1)
        else $error("operation overran its time");
    vector_fixed_a: assert property (ctl_wr |=> $stable(reset_vec))
        else $error("software write moved reset vector");
endmodule

// File: bench/tb_flash_self_program_sequencer.sv
// ============================================================
// Self-checking bench: core end and device end joined by the link.
// Assumes 50 MHz clock and a shortened programming time.
`timescale 1ns/100ps
module tb_flash_self_program_sequencer;
    import fsps_pkg::*;
    localparam int unsigned SIM_PROG = 20;          // Short programming time
    logic              mclk;                        // Clock
    logic              rst;                         // Reset
    logic [1:0]        addr;                        // Register address
    logic [15:0]       wr_data;                     // Write data
    logic              wr_en;                       // Write strobe
    logic              rd_en;                       // Read strobe
    logic [15:0]       rd_data;                     // Read data
    logic              ee_wr_req;                   // EEPROM write
    logic              stalled;                     // Core halted
    logic              irq_req;                     // Interrupt
    logic              fuse;                        // Boot vector fuse
    logic [PAGE_W-1:0] flash_page;                  // Latched page
    logic [15:0]       buf_rd_word;                 // Buffer word
    logic [WORD_W-1:0] buf_rd_idx;                  // Buffer index echo
    logic              flash_erase;                 // Erase pulse
    logic              flash_write;                 // Write pulse
    logic              flash_lock;                  // Lock pulse
    logic [15:0]       flash_lock_data;             // Lock data
    int                n_er, n_wr, n_lk;            // Flash pulses seen
    int                n_fail;                      // Mismatches
    int                cmp_count;                   // Comparisons
    fsps_if u_fsps_if ();
    fsps_core u_fsps_core (.mclk(mclk), .rst(rst), .lnk(u_fsps_if), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .ee_wr_req(ee_wr_req), .stalled(stalled), .irq_req(irq_req));
    fsps_device #(.PROG_CYC(SIM_PROG)) u_fsps_device (.mclk(mclk), .rst(rst),
        .lnk(u_fsps_if), .boot_vector_select_fuse(fuse), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_lock(flash_lock), .flash_page(flash_page),
        .flash_lock_data(flash_lock_data), .buf_rd_idx(buf_rd_idx),
        .buf_rd_word(buf_rd_word));
    fsps_link_monitor #(.PROG_CYC(SIM_PROG)) u_fsps_link_monitor (.mclk(mclk), .rst(rst),
        .ctl_wr(u_fsps_if.ctl_wr), .ctl_wdata(u_fsps_if.ctl_wdata),
        .ctl_rdata(u_fsps_if.ctl_rdata), .store(u_fsps_if.store), .ptr(u_fsps_if.ptr),
        .halt(u_fsps_if.halt), .irq(u_fsps_if.irq), .reset_vec(u_fsps_if.reset_vec));
    // ========================================================
    // Clock and shared tasks
    // ========================================================
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Count flash pulses; scenarios compare the change across one command
    always @(posedge mclk) begin
        if (flash_erase === 1'b1)
            n_er++;
        if (flash_write === 1'b1)
            n_wr++;
        if (flash_lock === 1'b1)
            n_lk++;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge mclk);
        wr_en   <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic do_reset(input logic f);
        @(posedge mclk);
        rst  <= 1'b1;
        fuse <= f;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask
    // Pointer, data pair, command, then store well inside the window
    task automatic issue(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d);
        bus_wr(2'd1, p);
        bus_wr(2'd2, d);
        bus_wr(2'd0, {8'h00, c});
        bus_wr(2'd3, 16'h0000);
    endtask
    task automatic load(input int w, input logic [15:0] d);
        issue({1'b0, CMD_LOAD}, 16'(w << 1), d);
    endtask
    task automatic peek(input int w, input logic [15:0] exp);
        logic [15:0] v;
        bus_wr(2'd1, 16'(w << 1));
        repeat (2) @(posedge mclk);
        #1 chk(buf_rd_word, exp);
        chk(16'(buf_rd_idx), 16'(w));
        bus_rd(2'd1, v);
        chk(v, 16'(w << 1));
    endtask
    task automatic reen();
        logic [15:0] v;
        bus_wr(2'd0, {9'h000, CMD_REENABLE});
        bus_rd(2'd0, v);
        chk(v & 16'h0040, 16'h0000);
    endtask
    // ========================================================
    // Scenarios
    // ========================================================
    task automatic t_vector();
        logic [15:0] v;
        do_reset(1'b1);
        bus_rd(2'd3, v);
        chk(v, APP_RESET_ADDR);
        do_reset(1'b0);
        bus_rd(2'd3, v);
        chk(v, BOOT_RESET_ADDR);
    endtask
    // Store on the last window cycle loads; one cycle later nothing starts
    task automatic t_window();
        logic [15:0] v;
        bus_wr(2'd1, 16'(7 << 1));
        bus_wr(2'd2, 16'h7777);
        bus_wr(2'd0, {9'h000, CMD_LOAD});
        repeat (2) @(posedge mclk);
        bus_wr(2'd3, 16'h0000);
        peek(7, 16'h7777);
        bus_wr(2'd1, 16'(3 << PAGE_LSB));
        bus_wr(2'd0, {9'h000, CMD_ERASE});
        repeat (3) @(posedge mclk);
        bus_wr(2'd3, 16'h0000);
        bus_rd(2'd0, v);
        chk(v & 16'h005f, 16'h0000);
    endtask
    // Lock-set takes the data pair and ignores the pointer
    task automatic t_lock();
        int n0;
        n0 = n_lk;
        issue({1'b1, CMD_LOCK}, 16'h5a5a, 16'h00c3);
        repeat (SIM_PROG + 4) @(posedge mclk);
        #1 chk(16'(n_lk - n0), 16'h0001);
        chk(flash_lock_data, 16'h00c3);
        chk(16'(irq_req), 16'h0001);
    endtask
    // Interrupt enabled so completion shows as a level request
    task automatic prog(input logic [6:0] c, input int pg, input logic h);
        logic [15:0] v;
        int          k;
        int          e0;
        int          w0;
        e0 = n_er;
        w0 = n_wr;
        issue({1'b1, c}, 16'(pg << PAGE_LSB), 16'h0000);
        bus_wr(2'd1, 16'hffff);
        #1 chk(16'(stalled), 16'(h));
        chk(16'(irq_req), 16'h0000);
        bus_rd(2'd0, v);
        chk(v & 16'h0040, 16'h0040);
        for (k = 0; k < 200 && irq_req !== 1'b1; k++)
            @(posedge mclk);
        #1 chk(16'(irq_req), 16'h0001);
        chk(16'(stalled), 16'h0000);
        chk(16'(flash_page), 16'(pg));
        bus_rd(2'd0, v);
        chk(v & 16'h0041, 16'h0040);
        chk(16'(n_er - e0), (c == CMD_ERASE) ? 16'h0001 : 16'h0000);
        chk(16'(n_wr - w0), (c == CMD_WRITE) ? 16'h0001 : 16'h0000);
    endtask
    task automatic t_buffer();
        prog(CMD_ERASE, 3, 1'b0);
        load(5, 16'ha5a5);
        load(2, 16'h0f0f);
        load(5, 16'h1111);
        peek(5, 16'ha5a5);
        peek(2, 16'h0f0f);
        prog(CMD_WRITE, 3, 1'b0);
        peek(5, 16'hffff);
        reen();
        load(4, 16'h1234);
        @(posedge mclk);
        ee_wr_req <= 1'b1;
        @(posedge mclk);
        ee_wr_req <= 1'b0;
        peek(4, 16'hffff);
        load(6, 16'h5a5a);
        reen();
        peek(6, 16'hffff);
    endtask
    // ========================================================
    // Main sequence and watchdog
    // ========================================================
    initial begin
        rst       = 1'b1;
        addr      = 2'd0;
        wr_data   = 16'h0000;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        ee_wr_req = 1'b0;
        fuse      = 1'b1;
        n_fail    = 0;
        cmp_count = 0;
        n_er      = 0;
        n_wr      = 0;
        n_lk      = 0;
        t_vector();
        t_window();
        t_buffer();
        t_lock();
        prog(CMD_ERASE, 120, 1'b1);
        reen();
        finish_test();
    end
    // Whole run needs a few hundred cycles; cut a hang well beyond that
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
endmodule
